// *** core/adcgv_params.svh ***
// Register offsets, field positions, reset values and limits for the channel slice
`ifndef ADCGV_PARAMS_SVH
`define ADCGV_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADCGV_ADDR_CH1_ANALOG_GAIN   8'h3d
`define ADCGV_ADDR_CH1_DIGITAL_VOL   8'h3e
`define ADCGV_ADDR_CODE_A_TRIM     8'h3f
`define ADCGV_ADDR_CH1_PHASE_TRIM    8'h40
`define ADCGV_ADDR_CH2_INPUT_SETUP   8'h41

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ADCGV_RST_CH1_ANALOG_GAIN    8'h00
`define ADCGV_RST_CH1_DIGITAL_VOL    8'hc9
`define ADCGV_RST_CODE_A_TRIM      8'h80
`define ADCGV_RST_CH1_PHASE_TRIM     8'h00
`define ADCGV_RST_CH2_INPUT_SETUP    8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCGV_GAIN_MSB               7
`define ADCGV_GAIN_LSB               2
`define ADCGV_GAIN_RSV_BIT           1
`define ADCGV_TRIM_MSB               7
`define ADCGV_TRIM_LSB               4
`define ADCGV_CH2_KIND_BIT           7
`define ADCGV_CH2_SRC_MSB            6
`define ADCGV_CH2_SRC_LSB            5
`define ADCGV_CH2_COUPLING_BIT       4
`define ADCGV_CH2_RANGE_BIT          3
`define ADCGV_CH2_AMP_MSB            2
`define ADCGV_CH2_AMP_LSB            1
`define ADCGV_CH2_AGC_BIT            0

// ----------------------------------------------------------------------------
// Code limits and unity points
// ----------------------------------------------------------------------------
`define ADCGV_GAIN_MAX_CODE          6'h2a
`define ADCGV_VOL_MUTE_CODE          8'h00
`define ADCGV_VOL_UNITY_CODE         9'h0c9
`define ADCGV_TRIM_UNITY_CODE        4'h8
`define ADCGV_PHASE_DEPTH            255

`endif

// *** core/adcgv_pkg.sv ***
// Types shared by the channel gain, volume and calibration register slice
package adcgv_pkg;

    // ------------------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [5:0]       gain;        // Analog gain code field
        logic             gain_rsv;    // Writable reserved bit
        logic [7:0]       volume;      // Digital volume code
        logic [3:0]       trim;        // Gain trim code field
        logic [7:0]       phase;       // Phase delay code
        logic [7:0]       ch2_setup;   // Channel 2 input setup
        logic [7:0]       rd_data;     // Registered read answer
        logic             rd_valid;    // Read answer strobe
        logic [5:0]       gain_code;   // Applied analog gain in dB
        logic             mute;        // Output silenced
        logic signed [8:0] vol_level;  // Applied level in half-dB steps
        logic signed [3:0] trim_level; // Applied trim in tenth-dB steps
    } adcgv_state_s;

    // Access kind of the register port
    typedef enum logic [1:0] {
        ADCGV_ACC_IDLE  = 2'b00,
        ADCGV_ACC_WRITE = 2'b01,
        ADCGV_ACC_READ  = 2'b10
    } adcgv_access_e;

endpackage : adcgv_pkg

// *** core/adcgv_delay_line.sv ***
// Tapped delay of the modulator bit stream, counted in modulator ticks
`timescale 1ns/100ps
`include "adcgv_params.svh"

module adcgv_delay_line #(
    parameter int DEPTH = `ADCGV_PHASE_DEPTH
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    // Stream
    input  wire logic       tick_in,
    input  wire logic       bit_in,
    input  wire logic [7:0] delay_in,
    output logic            bit_out
);
    import adcgv_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0] line;   // line[k] holds the input of k+1 ticks ago
        logic             out;
    } adcgv_dly_s;

    adcgv_dly_s state;
    adcgv_dly_s next_state;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Zero delay passes the current bit; the output flop is common to all
    // codes, so every code sees the same one-tick register latency.
    always_comb begin
        next_state = state;
        if (tick_in) begin
            if (delay_in == 8'h00) begin
                next_state.out = bit_in;
            end else begin
                next_state.out = state.line[delay_in - 8'h01];
            end
            next_state.line = {state.line[DEPTH-2:0], bit_in};
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign bit_out = state.out;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_delay_zero_pass: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && tick_in && delay_in == 8'h00) |=> (bit_out == $past(bit_in)))
        else $error("zero phase code did not pass the bit straight");

    a_delay_one_tick: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && tick_in && delay_in == 8'h01) |=> (bit_out == $past(state.line[0])))
        else $error("phase code one did not delay by one tick");

endmodule : adcgv_delay_line

// *** core/adcgv_regs.sv ***
// Channel gain, volume, calibration registers and channel 1 stream path
`timescale 1ns/100ps
`include "adcgv_params.svh"

module adcgv_regs (
    // Clock, reset and freeze
    input  wire logic                 clock_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 ce_in,
    // Register port from the control-port decoder
    input  wire adcgv_pkg::adcgv_access_e acc_in,
    input  wire logic [7:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    output logic [7:0]                rdata_out,
    output logic                      rvalid_out,
    // Channel 1 analog and digital settings
    output logic [5:0]                code_a_db_out,
    output logic                      ch1_mute_out,
    output logic signed [8:0]         ch1_volume_half_db_out,
    output logic signed [3:0]         ch1_trim_tenth_db_out,
    // Channel 1 modulator stream
    input  wire logic                 mod_tick_in,
    input  wire logic                 mod_bit_in,
    output logic                      ch1_bit_out,
    // Channel 2 input setup
    output logic                      ch2_input_kind_out,
    output logic [1:0]                ch2_input_source_out,
    output logic                      ch2_coupling_select_out,
    output logic                      ch2_swing_range_out,
    output logic [1:0]                ch2_amplifier_mode_out,
    output logic                      ch2_auto_gain_enable_out
);
    import adcgv_pkg::*;

    adcgv_state_s state;
    adcgv_state_s next_state;
    logic [7:0]   read_mux;

    // ------------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------------
    // Read-only bits are assembled as zero, the reserved gain bit reads back as written; unmapped offsets answer zero
    always_comb begin
        case (addr_in)
            `ADCGV_ADDR_CH1_ANALOG_GAIN: read_mux = {state.gain, state.gain_rsv, 1'b0};
            `ADCGV_ADDR_CH1_DIGITAL_VOL: read_mux = state.volume;
            `ADCGV_ADDR_CODE_A_TRIM:   read_mux = {state.trim, 4'h0};
            `ADCGV_ADDR_CH1_PHASE_TRIM:  read_mux = state.phase;
            `ADCGV_ADDR_CH2_INPUT_SETUP: read_mux = state.ch2_setup;
            default:                     read_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_state          = state;
        next_state.rd_valid = 1'b0;
        // Register writes; read-only bits are simply not stored
        if (acc_in == ADCGV_ACC_WRITE) begin
            case (addr_in)
                `ADCGV_ADDR_CH1_ANALOG_GAIN: begin
                    next_state.gain     = wdata_in[`ADCGV_GAIN_MSB:`ADCGV_GAIN_LSB];
                    next_state.gain_rsv = wdata_in[`ADCGV_GAIN_RSV_BIT];
                end
                `ADCGV_ADDR_CH1_DIGITAL_VOL: begin
                    next_state.volume = wdata_in;
                end
                `ADCGV_ADDR_CODE_A_TRIM: begin
                    next_state.trim = wdata_in[`ADCGV_TRIM_MSB:`ADCGV_TRIM_LSB];
                end
                `ADCGV_ADDR_CH1_PHASE_TRIM: begin
                    next_state.phase = wdata_in;
                end
                `ADCGV_ADDR_CH2_INPUT_SETUP: begin
                    next_state.ch2_setup = wdata_in;
                end
                default: begin
                    next_state.rd_valid = 1'b0;
                end
            endcase
        end else if (acc_in == ADCGV_ACC_READ) begin
            next_state.rd_data  = read_mux;
            next_state.rd_valid = 1'b1;
        end
        // Reserved gain codes saturate at the top step so the amplifier never
        // sees an undefined setting; the register still holds what was written
        if (state.gain > `ADCGV_GAIN_MAX_CODE) begin
            next_state.gain_code = `ADCGV_GAIN_MAX_CODE;
        end else begin
            next_state.gain_code = state.gain;
        end
        // Code zero is a hard mute, not the bottom of the attenuation range
        next_state.mute      = (state.volume == `ADCGV_VOL_MUTE_CODE);
        next_state.vol_level = $signed({1'b0, state.volume}) - $signed(`ADCGV_VOL_UNITY_CODE);
        next_state.trim_level = $signed(state.trim - `ADCGV_TRIM_UNITY_CODE);
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // All state holds while the clock enable is low
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state            <= '0;
            state.gain       <= 6'(`ADCGV_RST_CH1_ANALOG_GAIN >> `ADCGV_GAIN_LSB);
            state.volume     <= `ADCGV_RST_CH1_DIGITAL_VOL;
            state.trim       <= 4'(`ADCGV_RST_CODE_A_TRIM >> `ADCGV_TRIM_LSB);
            state.phase      <= `ADCGV_RST_CH1_PHASE_TRIM;
            state.ch2_setup  <= `ADCGV_RST_CH2_INPUT_SETUP;
            state.vol_level  <= 9'sh000;
            state.trim_level <= 4'sh0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Channel 1 phase delay
    // ------------------------------------------------------------------------
    // Mute is applied after the delay in the stream output below
    logic delayed_bit;

    adcgv_delay_line #(
        .DEPTH (`ADCGV_PHASE_DEPTH)
    ) u_phase_delay (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .tick_in  (mod_tick_in),
        .bit_in   (mod_bit_in),
        .delay_in (state.phase),
        .bit_out  (delayed_bit)
    );

    // Muted stream is forced to zero; a real volume multiply lies downstream
    logic stream_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stream_q <= 1'b0;
        end else if (ce_in) begin
            stream_q <= delayed_bit & ~state.mute;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------------
    assign rdata_out                = state.rd_data;
    assign rvalid_out               = state.rd_valid;
    assign code_a_db_out          = state.gain_code;
    assign ch1_mute_out             = state.mute;
    assign ch1_volume_half_db_out   = state.vol_level;
    assign ch1_trim_tenth_db_out    = state.trim_level;
    assign ch1_bit_out              = stream_q;
    assign ch2_input_kind_out       = state.ch2_setup[`ADCGV_CH2_KIND_BIT];
    assign ch2_input_source_out     = state.ch2_setup[`ADCGV_CH2_SRC_MSB:`ADCGV_CH2_SRC_LSB];
    assign ch2_coupling_select_out  = state.ch2_setup[`ADCGV_CH2_COUPLING_BIT];
    assign ch2_swing_range_out      = state.ch2_setup[`ADCGV_CH2_RANGE_BIT];
    assign ch2_amplifier_mode_out   = state.ch2_setup[`ADCGV_CH2_AMP_MSB:`ADCGV_CH2_AMP_LSB];
    assign ch2_auto_gain_enable_out = state.ch2_setup[`ADCGV_CH2_AGC_BIT];

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_gain_code_cap: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.gain > 6'h2a) |=> (code_a_db_out == 6'h2a))
        else $error("reserved gain code not held at the top step");

    a_gain_code_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && acc_in == ADCGV_ACC_WRITE && addr_in == 8'h3d && wdata_in[7:2] <= 6'h2a)
        |=> ##1 (code_a_db_out == $past(wdata_in[7:2], 2)))
        else $error("gain write not applied two cycles later");

    a_gain_bit0_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && acc_in == ADCGV_ACC_READ && addr_in == 8'h3d) |=> (rdata_out[0] == 1'b0))
        else $error("read-only gain bit 0 read as one");

    a_mute_on_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.volume == 8'h00) |=> ch1_mute_out)
        else $error("volume code zero did not mute");

    // The stream flop lags the mute flag by one cycle
    a_mute_stream_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.mute) |=> !ch1_bit_out)
        else $error("muted channel still sent a one");

    a_volume_level: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.volume == 8'hff) |=> (ch1_volume_half_db_out == 9'sd54))
        else $error("top volume code not at 27 dB");

    a_volume_floor: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.volume == 8'h01) |=> (ch1_volume_half_db_out == -9'sd200 && !ch1_mute_out))
        else $error("volume code one not at -100 dB");

    a_reset_values: assert property (@(posedge clock_in)
        $rose(rst_n_in) |-> (state.volume == 8'hc9 && state.trim == 4'h8 && state.phase == 8'h00
                             && state.gain == 6'h00 && state.ch2_setup == 8'h10))
        else $error("register reset value wrong");

    a_trim_level: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state.trim == 4'h0) |=> (ch1_trim_tenth_db_out == -4'sd8))
        else $error("trim code zero not at -0.8 dB");

    a_trim_low_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && acc_in == ADCGV_ACC_READ && addr_in == 8'h3f) |=> (rdata_out[3:0] == 4'h0))
        else $error("reserved trim bits read non-zero");

    a_coupling_map: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && acc_in == ADCGV_ACC_WRITE && addr_in == 8'h41)
        |=> (ch2_coupling_select_out == $past(wdata_in[4])))
        else $error("coupling select not taken from bit 4");

endmodule : adcgv_regs

// *** verification/adcgv_host_model.sv ***
// Host model that reaches the channel registers through the register port
`timescale 1ns/100ps
`include "adcgv_params.svh"

module adcgv_host_model (
    // Clock
    input  wire logic                 clock_in,
    // Register port
    output adcgv_pkg::adcgv_access_e  acc_out,
    output logic [7:0]                addr_out,
    output logic [7:0]                wdata_out,
    input  wire logic [7:0]           rdata_in,
    input  wire logic                 rvalid_in
);
    import adcgv_pkg::*;

    // Port starts idle
    initial begin
        acc_out = ADCGV_ACC_IDLE;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // One access per edge; everything changes only at the rising edge
    task automatic put(input adcgv_access_e k, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        acc_out <= k;
        addr_out <= a;
        wdata_out <= d;
    endtask : put

    // Idle cycles carry inverted values so a stale address never looks valid
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic raw);
        logic [7:0] v;
        v = d;
        if (!raw && a == `ADCGV_ADDR_CH1_ANALOG_GAIN) v[1:0] = 2'b00;
        if (!raw && a == `ADCGV_ADDR_CODE_A_TRIM) v[3:0] = 4'h0;
        if (!raw && a == `ADCGV_ADDR_CH2_INPUT_SETUP && v[4]) v[0] = 1'b0;
        put(ADCGV_ACC_WRITE, a, v);
        put(ADCGV_ACC_IDLE, ~a, ~v);
        @(posedge clock_in);
        @(negedge clock_in);
    endtask : write

    // Read, optionally right behind a write to the same place
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        if (wr) put(ADCGV_ACC_WRITE, a, d);
        put(ADCGV_ACC_READ, a, ~d);
        put(ADCGV_ACC_IDLE, ~a, d);
        // The answer strobe stands for one cycle only, so look right away
        @(negedge clock_in);
        q = rdata_in;
        ok = rvalid_in;
    endtask : access

endmodule : adcgv_host_model

// *** verification/adc_channel_gain_volume_calibration_tb.sv ***
// Self-checking bench for the channel gain, volume and calibration registers
`timescale 1ns/100ps

module adc_channel_gain_volume_calibration_tb;
    import adcgv_pkg::*;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic       raw;
        logic [2:0] sel;
        logic [8:0] x;
    } adcgv_row_s;

    logic clock_in, rst_n_in, ce_in, rvalid_out, ch1_mute_out, ch1_bit_out;
    logic mod_tick_in, mod_bit_in, ch2_input_kind_out, ch2_coupling_select_out;
    logic ch2_swing_range_out, ch2_auto_gain_enable_out, v;
    logic [1:0] ch2_input_source_out, ch2_amplifier_mode_out;
    logic [7:0] addr_in, wdata_in, rdata_out, d;
    logic [5:0] code_a_db_out;
    logic signed [8:0] ch1_volume_half_db_out;
    logic signed [3:0] ch1_trim_tenth_db_out;
    adcgv_access_e acc_in;
    int failures = 0, checked = 0, cycles = 0, first, highs;
    logic [7:0] rst_a[5] = '{8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41};
    logic [7:0] rst_v[5] = '{8'h00, 8'hc9, 8'h80, 8'h00, 8'h10};
    logic [7:0] ph[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
    // Address, data, read-back, raw, output picked, expected output
    adcgv_row_s rows[18] = '{
        '{8'h3d, 8'h00, 8'h00, 1'b0, 3'd1, 9'h000},
        '{8'h3d, 8'h07, 8'h04, 1'b0, 3'd1, 9'h001},
        '{8'h3d, 8'ha8, 8'ha8, 1'b0, 3'd1, 9'h02a},
        '{8'h3d, 8'hff, 8'hfe, 1'b1, 3'd1, 9'h02a},
        '{8'h3d, 8'h02, 8'h02, 1'b1, 3'd1, 9'h000},
        '{8'h3e, 8'h00, 8'h00, 1'b0, 3'd4, 9'h001},
        '{8'h3e, 8'h01, 8'h01, 1'b0, 3'd2, 9'h138},
        '{8'h3e, 8'hff, 8'hff, 1'b0, 3'd2, 9'h036},
        '{8'h3e, 8'hca, 8'hca, 1'b0, 3'd2, 9'h001},
        '{8'h3e, 8'hc9, 8'hc9, 1'b0, 3'd4, 9'h000},
        '{8'h3f, 8'h00, 8'h00, 1'b0, 3'd3, 9'h008},
        '{8'h3f, 8'hf0, 8'hf0, 1'b0, 3'd3, 9'h007},
        '{8'h3f, 8'hff, 8'hf0, 1'b1, 3'd3, 9'h007},
        '{8'h3f, 8'h80, 8'h80, 1'b0, 3'd3, 9'h000},
        '{8'h41, 8'hef, 8'hef, 1'b0, 3'd5, 9'h0ef},
        '{8'h41, 8'h11, 8'h10, 1'b0, 3'd5, 9'h010},
        '{8'h41, 8'h5a, 8'h5a, 1'b0, 3'd5, 9'h05a},
        '{8'h50, 8'h55, 8'h00, 1'b0, 3'd0, 9'h000}};

    adcgv_regs adcgv_regs_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .acc_in(acc_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .code_a_db_out(code_a_db_out),
        .ch1_mute_out(ch1_mute_out), .ch1_volume_half_db_out(ch1_volume_half_db_out),
        .ch1_trim_tenth_db_out(ch1_trim_tenth_db_out), .mod_tick_in(mod_tick_in),
        .mod_bit_in(mod_bit_in), .ch1_bit_out(ch1_bit_out),
        .ch2_input_kind_out(ch2_input_kind_out), .ch2_input_source_out(ch2_input_source_out),
        .ch2_coupling_select_out(ch2_coupling_select_out),
        .ch2_swing_range_out(ch2_swing_range_out),
        .ch2_amplifier_mode_out(ch2_amplifier_mode_out),
        .ch2_auto_gain_enable_out(ch2_auto_gain_enable_out));

    adcgv_host_model adcgv_host_model_i (.clock_in(clock_in), .acc_out(acc_in),
        .addr_out(addr_in), .wdata_out(wdata_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out));

    // 40 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Picks the output that a table row speaks about
    function automatic logic [8:0] seen_of(input logic [2:0] s);
        case (s)
            3'd1: return {3'b000, code_a_db_out};
            3'd2: return ch1_volume_half_db_out;
            3'd3: return {5'h00, ch1_trim_tenth_db_out};
            3'd4: return {8'h00, ch1_mute_out};
            default: return {1'b0, ch2_input_kind_out, ch2_input_source_out,
                             ch2_coupling_select_out, ch2_swing_range_out,
                             ch2_amplifier_mode_out, ch2_auto_gain_enable_out};
        endcase
    endfunction : seen_of

    // Every register back at its power-up value, derived outputs at unity
    task automatic check_resets();
        for (int i = 0; i < 5; i++) begin
            adcgv_host_model_i.access(1'b0, rst_a[i], 8'h00, d, v);
            check("reset value", d, rst_v[i]);
            check("read strobe", v, 1'b1);
        end
        check("unity gain", {3'b000, code_a_db_out}, 9'h000);
        check("unity mute", {8'h00, ch1_mute_out}, 9'h000);
        check("unity trim", {5'h00, ch1_trim_tenth_db_out}, 9'h000);
        check("unity volume", ch1_volume_half_db_out, 9'h000);
        check("ch2 setup", seen_of(3'd5), 9'h010);
    endtask : check_resets

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        mod_tick_in = 1'b0;
        mod_bit_in = 1'b0;
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        check_resets();
        $display("test done: reset values");
        foreach (rows[i]) begin
            adcgv_host_model_i.write(rows[i].a, rows[i].d, rows[i].raw);
            if (rows[i].sel != 3'd0) check("derived", seen_of(rows[i].sel), rows[i].x);
            adcgv_host_model_i.access(1'b0, rows[i].a, 8'h00, d, v);
            check("read back", d, rows[i].r);
        end
        $display("test done: register table");
        // Read right behind a write, then a write that a frozen clock enable must drop
        adcgv_host_model_i.access(1'b1, 8'h40, 8'h33, d, v);
        check("write then read", d, 8'h33);
        @(posedge clock_in);
        ce_in <= 1'b0;
        adcgv_host_model_i.write(8'h40, 8'h77, 1'b0);
        @(posedge clock_in);
        ce_in <= 1'b1;
        adcgv_host_model_i.access(1'b0, 8'h40, 8'h00, d, v);
        check("frozen write", d, 8'h33);
        $display("test done: back to back and freeze");
        // Impulse through the delay line; flush longer than the deepest setting
        foreach (ph[j]) begin
            adcgv_host_model_i.write(8'h40, ph[j], 1'b0);
            @(posedge clock_in);
            mod_tick_in <= 1'b1;
            mod_bit_in <= 1'b0;
            repeat (260) @(posedge clock_in);
            mod_bit_in <= 1'b1;
            @(posedge clock_in);
            mod_bit_in <= 1'b0;
            highs = 0;
            first = 0;
            for (int k = 0; k < 300; k++) begin
                @(negedge clock_in);
                if (ch1_bit_out === 1'b1) begin
                    highs++;
                    if (highs == 1) first = k;
                end
            end
            check("delay cycles", 9'(first), 9'(ph[j]) + 9'd1);
            check("pulse count", 9'(highs), 9'd1);
        end
        $display("test done: phase delay");
        // Mute must hold the stream at zero even with ones arriving
        adcgv_host_model_i.write(8'h40, 8'h00, 1'b0);
        adcgv_host_model_i.write(8'h3e, 8'h00, 1'b0);
        @(posedge clock_in);
        mod_bit_in <= 1'b1;
        repeat (10) @(negedge clock_in);
        check("muted stream", ch1_bit_out, 1'b0);
        adcgv_host_model_i.write(8'h3e, 8'hc9, 1'b0);
        repeat (4) @(negedge clock_in);
        check("unmuted stream", ch1_bit_out, 1'b1);
        $display("test done: mute");
        // Second reset in mid-run
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        check_resets();
        $display("test done: second reset");
        stop_test();
    end

endmodule : adc_channel_gain_volume_calibration_tb
